// File: txpo_overhead.sv
// transmit path overhead insertion with AXI4-Lite register slave
`timescale 1ns/10ps
module txpo_overhead
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // frame side
  input  wire logic              frame_start,
  input  wire logic              far_end_error_pin,
  input  wire logic              auto_remote_defect,
  output logic [7:0]             j1_byte,
  output logic [7:0]             c2_byte,
  output logic [7:0]             g1_byte,
  output logic [7:0]             h1_indication_value_a_byte,
  output logic [7:0]             h2_indication_value_a_byte,
  output logic                   indication_value_a_active
);

  logic [7:0]        trace_r;
  logic [7:0]        label_r;
  logic [7:0]        status_r;
  logic [7:0]        status_nxt;
  logic [7:0]        conc_lo_r;
  logic [7:0]        conc_hi_r;
  logic [2:0]        ctrl_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;

  // write channel
  wire aw_hs    = s_axi_awvalid & s_axi_awready;
  wire w_hs     = s_axi_wvalid & s_axi_wready;
  wire do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire [7:0] w_idx   = awaddr_r[9:2];
  wire       w_upper = (awaddr_r[ADDR_W-1:10] != '0);
  wire       w_lane0 = do_write & wstrb_r[0];
  wire hit_w_trace  = ~w_upper & (w_idx == txpo_pkg::TXPO_IDX_TRACE);
  wire hit_w_label  = ~w_upper & (w_idx == txpo_pkg::TXPO_IDX_LABEL);
  wire hit_w_status = ~w_upper & (w_idx == txpo_pkg::TXPO_IDX_STATUS);
  wire hit_w_clo    = ~w_upper & (w_idx == txpo_pkg::TXPO_IDX_CONC_LO);
  wire hit_w_chi    = ~w_upper & (w_idx == txpo_pkg::TXPO_IDX_CONC_HI);
  wire hit_w_ctrl   = ~w_upper & (w_idx == txpo_pkg::TXPO_IDX_CTRL);
  wire w_mapped     = hit_w_trace | hit_w_label | hit_w_status |
                      hit_w_clo | hit_w_chi | hit_w_ctrl;
  wire [7:0] wbyte  = wdata_r[7:0];
  wire b_hs         = s_axi_bvalid & s_axi_bready;
  // one write enable per register, from the decode above
  wire wr_trace     = w_lane0 & hit_w_trace;
  wire wr_label     = w_lane0 & hit_w_label;
  wire wr_status    = w_lane0 & hit_w_status;
  wire wr_clo       = w_lane0 & hit_w_clo;
  wire wr_chi       = w_lane0 & hit_w_chi;
  wire wr_ctrl      = w_lane0 & hit_w_ctrl;

  // read channel
  wire ar_hs    = s_axi_arvalid & s_axi_arready;
  wire [7:0] r_idx   = s_axi_araddr[9:2];
  wire       r_upper = (s_axi_araddr[ADDR_W-1:10] != '0);
  wire hit_r_trace  = ~r_upper & (r_idx == txpo_pkg::TXPO_IDX_TRACE);
  wire hit_r_label  = ~r_upper & (r_idx == txpo_pkg::TXPO_IDX_LABEL);
  wire hit_r_status = ~r_upper & (r_idx == txpo_pkg::TXPO_IDX_STATUS);
  wire hit_r_clo    = ~r_upper & (r_idx == txpo_pkg::TXPO_IDX_CONC_LO);
  wire hit_r_chi    = ~r_upper & (r_idx == txpo_pkg::TXPO_IDX_CONC_HI);
  wire hit_r_ctrl   = ~r_upper & (r_idx == txpo_pkg::TXPO_IDX_CTRL);
  wire r_mapped     = hit_r_trace | hit_r_label | hit_r_status |
                      hit_r_clo | hit_r_chi | hit_r_ctrl;
  // status readback shows the pending error count as well
  wire [7:0] rbyte  = ({8{hit_r_trace}}  & trace_r)   |
                      ({8{hit_r_label}}  & label_r)   |
                      ({8{hit_r_status}} & status_r)  |
                      ({8{hit_r_clo}}    & conc_lo_r) |
                      ({8{hit_r_chi}}    & conc_hi_r) |
                      ({8{hit_r_ctrl}}   & {5'h00, ctrl_r});

  // address is captured on its own handshake, in either order with data
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      awaddr_r      <= '0;
    end
    else if (aw_hs)
    begin
      s_axi_awready <= 1'b0;
      awaddr_r      <= s_axi_awaddr;
    end
    else if (b_hs)
    begin
      s_axi_awready <= 1'b1;
    end
  end

  // data likewise; only byte lane 0 carries register bits
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_wready <= 1'b1;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
    end
    else if (w_hs)
    begin
      s_axi_wready <= 1'b0;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
    end
    else if (b_hs)
    begin
      s_axi_wready <= 1'b1;
    end
  end

  // response one edge after both halves are held; readies stay low until it is taken
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= txpo_pkg::TXPO_RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= w_mapped ? txpo_pkg::TXPO_RESP_OKAY : txpo_pkg::TXPO_RESP_SLVERR;
    end
    else if (b_hs)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= txpo_pkg::TXPO_RESP_OKAY;
    end
    else if (ar_hs)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rbyte};
      s_axi_rresp   <= r_mapped ? txpo_pkg::TXPO_RESP_OKAY : txpo_pkg::TXPO_RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // programmed error count: software write wins over the self-clear,
  // so a count written in the insertion cycle stays pending
  wire [3:0] prog_err = status_r[txpo_pkg::TXPO_ST_ERR_LSB +: txpo_pkg::TXPO_ST_ERR_W];
  wire       err_sent = frame_start & (prog_err != 4'h0);

  always_comb
  begin
    status_nxt = status_r;
    if (wr_status)
    begin
      status_nxt = wbyte;
    end
    else if (err_sent)
    begin
      status_nxt[txpo_pkg::TXPO_ST_ERR_LSB +: txpo_pkg::TXPO_ST_ERR_W] = 4'h0;
    end
  end

  // one short block per register; writes land on the edge that raises bvalid
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      trace_r <= txpo_pkg::TXPO_RST_TRACE;
    else if (wr_trace)
      trace_r <= wbyte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      label_r <= txpo_pkg::TXPO_RST_LABEL;
    else if (wr_label)
      label_r <= wbyte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      status_r <= txpo_pkg::TXPO_RST_STATUS;
    else
      status_r <= status_nxt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      conc_lo_r <= txpo_pkg::TXPO_RST_CONC_LO;
    else if (wr_clo)
      conc_lo_r <= wbyte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      conc_hi_r <= txpo_pkg::TXPO_RST_CONC_HI;
    else if (wr_chi)
      conc_hi_r <= wbyte;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      ctrl_r <= txpo_pkg::TXPO_RST_CTRL;
    else if (wr_ctrl)
      ctrl_r <= wbyte[2:0];
  end

  logic [3:0] pin_err_count;

  txpo_err_count u_err_count
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .err_pin     (far_end_error_pin),
    .frame_start (frame_start),
    .last_count  (pin_err_count)
  );

  // path status byte assembly
  wire enh_en  = ctrl_r[txpo_pkg::TXPO_CTRL_ENH_EN_BIT];
  wire enh_src = ctrl_r[txpo_pkg::TXPO_CTRL_ENH_SRC_BIT];
  wire sw_bits_ignored = ~enh_en | (enh_en & enh_src);
  wire [3:0] err_field = (prog_err != 4'h0) ? prog_err : pin_err_count;
  // when software bits are ignored the receive side defect drives it
  wire path_remote_defect_bit  = sw_bits_ignored ? auto_remote_defect
                                   : status_r[txpo_pkg::TXPO_ST_PATH_REMOTE_DEFECT_BIT];
  wire [1:0] spare_bits = sw_bits_ignored ? 2'h0
                                          : status_r[txpo_pkg::TXPO_ST_SPARE_LSB +: 2];
  wire aux_remote_defect_bit = status_r[txpo_pkg::TXPO_ST_AUX_REMOTE_DEFECT_BIT];

  logic [7:0] g1_nxt;

  always_comb
  begin
    g1_nxt = 8'h00;
    g1_nxt[txpo_pkg::TXPO_G1_ERR_LSB +: 4]   = err_field;
    g1_nxt[txpo_pkg::TXPO_G1_PATH_REMOTE_DEFECT_BIT]       = path_remote_defect_bit;
    g1_nxt[txpo_pkg::TXPO_G1_SPARE_LSB +: 2] = spare_bits;
    g1_nxt[txpo_pkg::TXPO_G1_AUX_REMOTE_DEFECT_BIT]      = aux_remote_defect_bit;
  end

  // all overhead changes only at a frame boundary, never mid-frame
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      j1_byte        <= txpo_pkg::TXPO_RST_TRACE;
      c2_byte        <= txpo_pkg::TXPO_RST_LABEL;
      g1_byte        <= 8'h00;
      h1_indication_value_a_byte <= txpo_pkg::TXPO_RST_CONC_HI;
      h2_indication_value_a_byte <= txpo_pkg::TXPO_RST_CONC_LO;
      indication_value_a_active  <= txpo_pkg::TXPO_RST_CTRL[txpo_pkg::TXPO_CTRL_INDICATION_VALUE_A_BIT];
    end
    else if (frame_start)
    begin
      j1_byte        <= trace_r;
      c2_byte        <= label_r;
      g1_byte        <= g1_nxt;
      h1_indication_value_a_byte <= conc_hi_r;
      h2_indication_value_a_byte <= conc_lo_r;
      indication_value_a_active  <= ctrl_r[txpo_pkg::TXPO_CTRL_INDICATION_VALUE_A_BIT];
    end
  end

endmodule : txpo_overhead

// File: txpo_pkg.sv
// constants, register map and field layout for transmit path overhead insertion
package txpo_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] TXPO_IDX_TRACE   = 8'h47;
  localparam logic [7:0] TXPO_IDX_LABEL   = 8'h48;
  localparam logic [7:0] TXPO_IDX_STATUS  = 8'h49;
  localparam logic [7:0] TXPO_IDX_CONC_LO = 8'h4e;
  localparam logic [7:0] TXPO_IDX_CONC_HI = 8'h4f;
  localparam logic [7:0] TXPO_IDX_CTRL    = 8'h50;

  // reset values
  localparam logic [7:0] TXPO_RST_TRACE   = 8'h00;
  localparam logic [7:0] TXPO_RST_LABEL   = 8'h01;
  localparam logic [7:0] TXPO_RST_STATUS  = 8'h00;
  localparam logic [7:0] TXPO_RST_CONC_LO = 8'hff;
  localparam logic [7:0] TXPO_RST_CONC_HI = 8'h93;
  localparam logic [2:0] TXPO_RST_CTRL    = 3'h4;

  // path status control register fields
  localparam int TXPO_ST_ERR_LSB   = 4;
  localparam int TXPO_ST_ERR_W     = 4;
  localparam int TXPO_ST_PATH_REMOTE_DEFECT_BIT  = 3;
  localparam int TXPO_ST_AUX_REMOTE_DEFECT_BIT = 2;
  localparam int TXPO_ST_SPARE_LSB = 0;

  // transmitted path status byte positions
  localparam int TXPO_G1_ERR_LSB   = 4;
  localparam int TXPO_G1_PATH_REMOTE_DEFECT_BIT  = 3;
  localparam int TXPO_G1_SPARE_LSB = 1;
  localparam int TXPO_G1_AUX_REMOTE_DEFECT_BIT = 0;

  // own control register fields
  localparam int TXPO_CTRL_ENH_EN_BIT  = 0;
  localparam int TXPO_CTRL_ENH_SRC_BIT = 1;
  localparam int TXPO_CTRL_INDICATION_VALUE_A_BIT  = 2;

  // largest error count the pin counter can report for a frame
  localparam logic [3:0] TXPO_ERR_MAX = 4'h8;

  localparam logic [1:0] TXPO_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TXPO_RESP_SLVERR = 2'h2;

endpackage : txpo_pkg

// File: txpo_err_count.sv
// per-frame count of far-end error pulses from the error input pin
`timescale 1ns/10ps
module txpo_err_count
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       err_pin,
  input  wire logic       frame_start,
  output logic      [3:0] last_count
);

  logic       sync1_r;
  logic       sync2_r;
  logic       prev_r;
  logic [3:0] acc_r;
  logic [3:0] acc_nxt;
  logic       err_edge;

  // pin is asynchronous to ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end
    else
    begin
      sync1_r <= err_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  assign err_edge = sync2_r & ~prev_r;

  // saturate: the pin count never reports more than the maximum in G1
  assign acc_nxt = (acc_r == txpo_pkg::TXPO_ERR_MAX) ? acc_r : acc_r + 4'h1;

  // a pulse landing with frame_start belongs to the frame that starts
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acc_r <= 4'h0;
    end
    else if (frame_start)
    begin
      acc_r <= err_edge ? 4'h1 : 4'h0;
    end
    else if (err_edge)
    begin
      acc_r <= acc_nxt;
    end
  end

  // count of the frame now closing, read by the inserter at frame_start
  assign last_count = acc_r;

endmodule : txpo_err_count

// File: txpo_chk_sva.sv
// checker for overhead outputs and register bus handshakes
`timescale 1ns/10ps
module txpo_chk
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        frame_start,
  input wire logic [7:0]  j1_byte,
  input wire logic [7:0]  c2_byte,
  input wire logic [7:0]  g1_byte,
  input wire logic [7:0]  h1_indication_value_a_byte,
  input wire logic [7:0]  h2_indication_value_a_byte,
  input wire logic        indication_value_a_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_aw; s_axi_awvalid && s_axi_awready; endsequence
  sequence s_w; s_axi_wvalid && s_axi_wready; endsequence
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  property p_wr_answer; (s_aw and s_w) |=> ##1 s_axi_bvalid; endproperty
  property p_rd_answer; s_ar |=> s_axi_rvalid; endproperty
  property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_w_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  // a mid-frame change would mix old and new overhead
  property p_hold; !frame_start |=> $stable({j1_byte, c2_byte, g1_byte, h1_indication_value_a_byte,
    h2_indication_value_a_byte, indication_value_a_active}); endproperty
  property p_rst_val; $fell(rst) |-> j1_byte == 8'h00 && c2_byte == 8'h01 &&
    h1_indication_value_a_byte == 8'h93 && h2_indication_value_a_byte == 8'hff; endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("no write response");
  a_rd_answer: assert property (p_rd_answer) else $error("no read response");
  a_b_stands: assert property (p_b_stands) else $error("write response dropped");
  a_r_stands: assert property (p_r_stands) else $error("read data dropped");
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  a_hold: assert property (p_hold) else $error("overhead changed mid frame");
  a_rst_val: assert property (p_rst_val) else $error("bad reset overhead");
endmodule : txpo_chk
bind txpo_overhead txpo_chk u_chk (.*);

// File: txpo_far_end.sv
// far-end model: frame pulses and error pin pulses on request
`timescale 1ns/10ps
module txpo_far_end
(
  input  wire logic ref_clk,
  input  wire logic frame_req,
  input  wire logic err_req,
  output logic      frame_start,
  output logic      far_end_error_pin
);
  initial frame_start = 1'b0;
  initial far_end_error_pin = 1'b0;
  always @(posedge ref_clk)
  begin
    frame_start <= frame_req;
    far_end_error_pin <= err_req;
  end
endmodule : txpo_far_end

// File: txpo_overhead_tb.sv
// self-checking bench for transmit path overhead insertion
`timescale 1ns/10ps
module txpo_overhead_tb;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic        s_axi_rready = 0, auto_remote_defect = 0, frame_req = 0, err_req = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, r2;
  logic        frame_start, far_end_error_pin, indication_value_a_active;
  logic [7:0]  j1_byte, c2_byte, g1_byte, h1_indication_value_a_byte, h2_indication_value_a_byte;
  logic [7:0]  ix[6] = '{8'h47, 8'h48, 8'h49, 8'h4e, 8'h4f, 8'h50};
  int          rg[6] = '{0, 1, 0, 255, 147, 4};
  int          num_errors = 0, checks = 0, pc = 0, seed = 32'h03da238c;
  logic [47:0] eo = {7'h0, 1'b1, 8'h00, 8'h01, 8'h00, 8'h93, 8'hff};
  always #25 ref_clk = ~ref_clk;
  txpo_overhead dut_u (.*);
  txpo_far_end fe_u (.*);
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] v, output logic [1:0] q);
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    q = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] v, output logic [1:0] q);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    v = s_axi_rdata;
    q = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
  // model: the pin count is used only when no programmed count waits
  task automatic frm;
    int s, e, ig;
    s = rg[2];
    ig = !rg[5][0] || rg[5][1];
    e = (s[7:4] != 0) ? s[7:4] : ((pc > 8) ? 8 : pc);
    eo = {7'h0, rg[5][2], 8'(rg[0]), 8'(rg[1]), 4'(e), ig ? auto_remote_defect : s[3],
          ig ? 2'b0 : 2'(s[1:0]), s[2], 8'(rg[4]), 8'(rg[3])};
    frame_req <= 1'b1;
    @(posedge ref_clk);
    frame_req <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rg[2] = s & 8'h0f;
    pc = 0;
    chk({7'h0, indication_value_a_active, j1_byte, c2_byte, g1_byte, h1_indication_value_a_byte, h2_indication_value_a_byte}, eo);
  endtask : frm
  task automatic pls(input int n);
    repeat (n)
    begin
      err_req <= 1'b1;
      @(posedge ref_clk);
      err_req <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (6) @(posedge ref_clk);
    pc += n;
  endtask : pls
  task automatic results;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    num_errors++;
    results;
  end
  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    foreach (ix[k])
    begin
      rd(ix[k], d, r);
      chk({14'h0, r, d}, 48'(rg[k]));
    end
    for (int m = 0; m < 5; m++)
    begin
      for (int k = 0; k < 5; k++) rg[k] = $random(seed) & 255;
      rg[2] &= 15;
      rg[5] = (m == 4) ? 0 : (m | 4);
      foreach (ix[k]) wr(ix[k], 8'(rg[k]), r);
      auto_remote_defect <= $random(seed);
      @(posedge ref_clk);
      chk({7'h0, indication_value_a_active, j1_byte, c2_byte, g1_byte, h1_indication_value_a_byte, h2_indication_value_a_byte}, eo);
      frm;
    end
    pls(3);
    frm;
    pls(10);
    rg[2] = 8'h5a;
    wr(ix[2], 8'h5a, r);
    rd(ix[2], d, r);
    chk({14'h0, r, d}, 48'h5a);
    frm;
    rd(ix[2], d, r);
    chk({14'h0, r, d}, 48'h0a);
    pls(10);
    frm;
    s_axi_wstrb <= 4'h0;
    wr(ix[0], ~8'(rg[0]), r);
    s_axi_wstrb <= 4'hf;
    rd(ix[0], d, r2);
    chk({12'h0, r, r2, d}, 48'(rg[0]));
    wr(8'h51, 8'h3c, r);
    rd(8'h51, d, r2);
    chk({12'h0, r, r2, d}, {12'h0, 4'ha, 32'h0});
    results;
  end
endmodule : txpo_overhead_tb
